// >>> verilog/qos_pkg.sv
// Shared constants for the per-port QoS classifier and egress scheduler.
package qos_pkg;

    localparam int NUM_QUEUES = 8;
    localparam int NUM_PORTS  = 8;
    localparam int ADDR_W     = 8;

    // Frame priority source selected by software.
    typedef enum logic [1:0] {
        TRUST_COS      = 2'b00,
        TRUST_DSCP     = 2'b01,
        TRUST_COS_DSCP = 2'b10
    } trust_type;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_PORT_TRUST = 8'h04;
    localparam logic [7:0] OFS_SCHED_MODE = 8'h08;
    localparam logic [7:0] OFS_COS_TO_Q   = 8'h0C;
    localparam logic [7:0] OFS_Q_TO_COS   = 8'h10;
    localparam logic [7:0] OFS_WEIGHT     = 8'h14;
    localparam logic [7:0] OFS_STATUS     = 8'h18;
    localparam logic [7:0] OFS_PORT_COS   = 8'h1C;
    localparam logic [7:0] OFS_DSCP_FIRST = 8'h20;
    localparam logic [7:0] OFS_DSCP_LAST  = 8'h3C;

    // Field positions.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_TRUST_LSB  = 1;
    localparam int STATUS_FULL_LSB = 8;
    localparam int TOS_DSCP_LSB    = 2;

    // Reset values; priority-to-queue and DSCP table entries hold zero-based queue numbers.
    localparam logic        RST_ENABLE     = 1'b1;
    localparam trust_type   RST_TRUST      = TRUST_COS;
    localparam logic [7:0]  RST_PORT_TRUST = 8'hFF;
    localparam logic [7:0]  RST_SCHED_MODE = 8'h00;
    localparam logic [23:0] RST_COS_TO_Q   = 24'hFAC688;
    localparam logic [23:0] RST_Q_TO_COS   = 24'hFAC688;
    localparam logic [31:0] RST_WEIGHT     = 32'hFD954321;
    localparam logic [23:0] RST_PORT_COS   = 24'h000000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Every code point of one class selector starts in the same queue.
    function automatic logic [23:0] dscpWordReset(input logic [2:0] k);
        dscpWordReset = {8{k}};
    endfunction : dscpWordReset

endpackage : qos_pkg

// >>> verilog/fifo_buffer.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module fifo_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,  // System clock.
    input  wire logic             rst,      // Synchronous reset, active high.
    input  wire logic             inValid,  // Write request.
    output logic                  inReady,  // Space available.
    input  wire logic [WIDTH-1:0] inData,   // Write data.
    output logic                  outValid, // Head entry present.
    input  wire logic             outReady, // Consumer takes head.
    output logic      [WIDTH-1:0] outData   // Head entry.
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [CW-1:0]               count;
    } fifo_state_type;

    fifo_state_type s_r;
    fifo_state_type s_nxt;
    logic           push;
    logic           pop;

    assign inReady  = (s_r.count != CW'(DEPTH));
    assign outValid = (s_r.count != '0);
    assign outData  = s_r.mem[s_r.rdPtr];

    always_comb
    begin
        s_nxt = s_r;
        push  = inValid && inReady;
        pop   = outValid && outReady;
        if (push)
        begin
            s_nxt.mem[s_r.wrPtr] = inData;
            s_nxt.wrPtr = (s_r.wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(s_r.wrPtr + 1'b1);
        end
        if (pop)
        begin
            s_nxt.rdPtr = (s_r.rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(s_r.rdPtr + 1'b1);
        end
        if (push && !pop)
        begin
            s_nxt.count = CW'(s_r.count + 1'b1);
        end
        else if (pop && !push)
        begin
            s_nxt.count = CW'(s_r.count - 1'b1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule : fifo_buffer

// >>> verilog/qos_classify_queue_scheduler.sv
// Per-port QoS: priority classification, eight egress queues, SP/WRR scheduler.
`timescale 1ns/1ps
// What this block does
// - Tag priority field is three bits, eight classes, seven highest.
// - IPv4 precedence bits give eight levels, seven highest down to zero.
// - DSCP is the six-bit code point; two low bits ignored.
// - Code points sharing the class selector code belong to one class.
// - Global enable turns classification and queuing on or off.
// - Trust mode selects VLAN priority, DSCP, or the combined source.
// - Port with trust off is not classified from header fields.
// - Each of eight queues selects strict priority or weighted round robin.
// - Strict priority serves higher queues first, lower ones afterwards.
// - WRR bandwidth follows weights, default 1,2,3,4,5,9,13,15.
// - Priority-to-queue table, default priority n to queue n.
// - Queue-to-priority table, default queue n gives priority n.
// - DSCP-to-queue table, default eight consecutive code points per queue.
module qos_classify_queue_scheduler
    import qos_pkg::*;
#(
    parameter int DATA_W     = 32,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic              sys_clk,   // System clock, 100 MHz.
    input  wire logic              rst,       // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0] awaddr,    // AXI write address.
    input  wire logic              awvalid,   // AXI write address valid.
    output logic                   awready,   // AXI write address ready.
    input  wire logic [31:0]       wdata,     // AXI write data.
    input  wire logic [3:0]        wstrb,     // AXI byte strobes.
    input  wire logic              wvalid,    // AXI write data valid.
    output logic                   wready,    // AXI write data ready.
    output logic [1:0]             bresp,     // AXI write response.
    output logic                   bvalid,    // AXI write response valid.
    input  wire logic              bready,    // AXI write response ready.
    input  wire logic [ADDR_W-1:0] araddr,    // AXI read address.
    input  wire logic              arvalid,   // AXI read address valid.
    output logic                   arready,   // AXI read address ready.
    output logic [31:0]            rdata,     // AXI read data.
    output logic [1:0]             rresp,     // AXI read response.
    output logic                   rvalid,    // AXI read data valid.
    input  wire logic              rready,    // AXI read data ready.
    input  wire logic              inValid,   // Ingress frame descriptor valid.
    output logic                   inReady,   // Target queue can take it.
    input  wire logic [2:0]        inPort,    // Ingress port number.
    input  wire logic              inTagged,  // Frame carries a VLAN tag.
    input  wire logic [2:0]        inPcp,     // VLAN priority field.
    input  wire logic              inIsIp,    // Frame is IPv4.
    input  wire logic [7:0]        inTos,     // Type-of-service / DS byte.
    input  wire logic [DATA_W-1:0] inData,    // Frame descriptor payload.
    output logic                   outValid,  // Egress descriptor valid.
    input  wire logic              outReady,  // Egress port takes it.
    output logic [DATA_W-1:0]      outData,   // Egress descriptor payload.
    output logic [2:0]             outQueue,  // Queue served, zero based.
    output logic [2:0]             outCos     // Priority from queue-to-priority table.
);

    typedef struct packed {
        logic                             enable;
        trust_type                        trust;
        logic [NUM_PORTS-1:0]             portTrust;
        logic [NUM_QUEUES-1:0]            wrrSel;
        logic [7:0][2:0]                  cosQ;
        logic [NUM_QUEUES-1:0][2:0]       qCos;
        logic [NUM_QUEUES-1:0][3:0]       weight;
        logic [NUM_PORTS-1:0][2:0]        portCos;
        logic [7:0][7:0][2:0]             dscpQ;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             rvalid;
        logic [1:0]                       rresp;
        logic [31:0]                      rdata;
        logic                             outValid;
        logic [DATA_W-1:0]                outData;
        logic [2:0]                       outQueue;
        logic [2:0]                       outCos;
        logic [2:0]                       wrrPtr;
        logic [3:0]                       credit;
    } state_type;

    state_type                              s_r;
    state_type                              s_nxt;
    logic [NUM_QUEUES-1:0]                  qPush;
    logic [NUM_QUEUES-1:0]                  qReady;
    logic [NUM_QUEUES-1:0]                  qValid;
    logic [NUM_QUEUES-1:0]                  qPop;
    logic [NUM_QUEUES-1:0][DATA_W-1:0]      qData;
    logic [2:0]                             targetQ;
    logic [5:0]                             dscp;
    logic [2:0]                             classSelectorCode;
    logic [2:0]                             portCosVal;
    logic [2:0]                             wAddrIdx;
    logic [31:0]                            wWord;
    logic                                   wrGo;
    logic                                   arGo;
    logic                                   take;
    logic                                   found;
    logic                                   viaWrr;
    logic [2:0]                             sel;
    logic [2:0]                             cand;
    logic [NUM_QUEUES-1:0]                  spMask;

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a <= OFS_DSCP_LAST);
    endfunction : isMapped

    function automatic logic [31:0] regValue(input state_type st,
                                             input logic [ADDR_W-1:0] a,
                                             input logic [NUM_QUEUES-1:0] ne,
                                             input logic [NUM_QUEUES-1:0] rdy);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        regValue = 32'h0000_0000;
        case (w)
            OFS_CTRL:       regValue[2:0] = {st.trust, st.enable};
            OFS_PORT_TRUST: regValue[NUM_PORTS-1:0] = st.portTrust;
            OFS_SCHED_MODE: regValue[NUM_QUEUES-1:0] = st.wrrSel;
            OFS_COS_TO_Q:   regValue[23:0] = st.cosQ;
            OFS_Q_TO_COS:   regValue[23:0] = st.qCos;
            OFS_WEIGHT:     regValue = st.weight;
            OFS_STATUS:     regValue[15:0] = {~rdy, ne};
            OFS_PORT_COS:   regValue[23:0] = st.portCos;
            default:
            begin
                if (w >= OFS_DSCP_FIRST && w <= OFS_DSCP_LAST)
                begin
                    regValue[23:0] = st.dscpQ[w[4:2]];
                end
            end
        endcase
    endfunction : regValue

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        for (int b = 0; b < 4; b++)
        begin
            mergeBytes[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction : mergeBytes

    genvar gq;
    generate
        for (gq = 0; gq < NUM_QUEUES; gq++)
        begin : gQueue
            fifo_buffer #(
                .WIDTH (DATA_W),
                .DEPTH (FIFO_DEPTH)
            ) queueFifo (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .inValid  (qPush[gq]),
                .inReady  (qReady[gq]),
                .inData   (inData),
                .outValid (qValid[gq]),
                .outReady (qPop[gq]),
                .outData  (qData[gq])
            );
        end
    endgenerate

    assign bvalid   = s_r.bvalid;
    assign bresp    = s_r.bresp;
    assign rvalid   = s_r.rvalid;
    assign rresp    = s_r.rresp;
    assign rdata    = s_r.rdata;
    assign outValid = s_r.outValid;
    assign outData  = s_r.outData;
    assign outQueue = s_r.outQueue;
    assign outCos   = s_r.outCos;

    always_comb
    begin
        s_nxt = s_r;
        // Classification of the ingress descriptor.
        dscp              = inTos[7:TOS_DSCP_LSB];
        classSelectorCode = dscp[5:3];
        portCosVal        = s_r.portCos[inPort];
        targetQ           = s_r.cosQ[portCosVal];
        if (!s_r.enable)
        begin
            targetQ = 3'h0;
        end
        else if (s_r.portTrust[inPort])
        begin
            case (s_r.trust)
                TRUST_DSCP:
                begin
                    if (inIsIp)
                    begin
                        targetQ = s_r.dscpQ[classSelectorCode][dscp[2:0]];
                    end
                end
                TRUST_COS_DSCP:
                begin
                    if (inIsIp)
                    begin
                        targetQ = s_r.dscpQ[classSelectorCode][dscp[2:0]];
                    end
                    else if (inTagged)
                    begin
                        targetQ = s_r.cosQ[inPcp];
                    end
                end
                default:
                begin
                    if (inTagged)
                    begin
                        targetQ = s_r.cosQ[inPcp];
                    end
                end
            endcase
        end
        // A full queue stalls the ingress side instead of dropping.
        inReady = qReady[targetQ];
        qPush   = '0;
        qPush[targetQ] = inValid;

        // Register bus: address and data are taken together.
        wrGo     = awvalid && wvalid && !s_r.bvalid;
        awready  = wrGo;
        wready   = wrGo;
        wAddrIdx = awaddr[4:2];
        wWord    = mergeBytes(regValue(s_r, awaddr, qValid, qReady), wdata, wstrb);
        if (s_r.bvalid && bready)
        begin
            s_nxt.bvalid = 1'b0;
        end
        if (wrGo)
        begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = isMapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
            case ({awaddr[ADDR_W-1:2], 2'b00})
                OFS_CTRL:
                begin
                    s_nxt.enable = wWord[CTRL_ENABLE_BIT];
                    s_nxt.trust  = trust_type'(wWord[CTRL_TRUST_LSB +: 2]);
                end
                OFS_PORT_TRUST: s_nxt.portTrust = wWord[NUM_PORTS-1:0];
                OFS_SCHED_MODE: s_nxt.wrrSel    = wWord[NUM_QUEUES-1:0];
                OFS_COS_TO_Q:   s_nxt.cosQ      = wWord[23:0];
                OFS_Q_TO_COS:   s_nxt.qCos      = wWord[23:0];
                OFS_WEIGHT:     s_nxt.weight    = wWord;
                OFS_PORT_COS:   s_nxt.portCos   = wWord[23:0];
                default:
                begin
                    if (awaddr >= OFS_DSCP_FIRST && isMapped(awaddr))
                    begin
                        s_nxt.dscpQ[wAddrIdx] = wWord[23:0];
                    end
                end
            endcase
        end
        arGo    = arvalid && !s_r.rvalid;
        arready = arGo;
        if (s_r.rvalid && rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
        if (arGo)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rdata  = regValue(s_r, araddr, qValid, qReady);
        end

        // Egress scheduler. With the function disabled all queues drain
        // as strict priority so nothing left behind is stranded.
        take   = !s_r.outValid || outReady;
        found  = 1'b0;
        viaWrr = 1'b0;
        sel    = 3'h0;
        cand   = 3'h0;
        qPop   = '0;
        spMask = s_r.enable ? ~s_r.wrrSel : {NUM_QUEUES{1'b1}};
        for (int q = 0; q < NUM_QUEUES; q++)
        begin
            if (spMask[q] && qValid[q])
            begin
                found = 1'b1;
                sel   = 3'(q);
            end
        end
        if (!found)
        begin
            if (qValid[s_r.wrrPtr] && s_r.credit < s_r.weight[s_r.wrrPtr])
            begin
                found  = 1'b1;
                viaWrr = 1'b1;
                sel    = s_r.wrrPtr;
            end
            else
            begin
                for (int i = 1; i <= NUM_QUEUES; i++)
                begin
                    cand = 3'(s_r.wrrPtr + 3'(i));
                    if (!found && qValid[cand] && !spMask[cand])
                    begin
                        found = 1'b1;
                        sel   = cand;
                    end
                end
            end
        end
        if (s_r.outValid && outReady)
        begin
            s_nxt.outValid = 1'b0;
        end
        if (take && found)
        begin
            qPop[sel]      = 1'b1;
            s_nxt.outValid = 1'b1;
            s_nxt.outData  = qData[sel];
            s_nxt.outQueue = sel;
            s_nxt.outCos   = s_r.qCos[sel];
            if (!spMask[sel])
            begin
                s_nxt.wrrPtr = sel;
                s_nxt.credit = viaWrr ? 4'(s_r.credit + 4'h1) : 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r           <= '0;
            s_r.enable    <= RST_ENABLE;
            s_r.trust     <= RST_TRUST;
            s_r.portTrust <= RST_PORT_TRUST;
            s_r.wrrSel    <= RST_SCHED_MODE;
            s_r.cosQ      <= RST_COS_TO_Q;
            s_r.qCos      <= RST_Q_TO_COS;
            s_r.weight    <= RST_WEIGHT;
            s_r.portCos   <= RST_PORT_COS;
            for (int k = 0; k < 8; k++)
            begin
                s_r.dscpQ[k] <= dscpWordReset(3'(k));
            end
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule : qos_classify_queue_scheduler

// >>> tb/qos_sva.sv
// Port assertions for the QoS classifier and scheduler.
`timescale 1ns/1ps
module qos_sva (
    input wire logic        sys_clk,  // Clock.
    input wire logic        rst,      // Reset.
    input wire logic        awvalid,  // Write address.
    input wire logic        wvalid,   // Write data.
    input wire logic        bvalid,   // Write answer.
    input wire logic        bready,   // Answer taken.
    input wire logic        arvalid,  // Read request.
    input wire logic        rvalid,   // Read answer.
    input wire logic        rready,   // Read taken.
    input wire logic [31:0] rdata,    // Read data.
    input wire logic        inValid,  // Offered.
    input wire logic        inReady,  // Accepted.
    input wire logic        outValid, // Egress valid.
    input wire logic        outReady, // Egress taken.
    input wire logic [2:0]  outQueue  // Queue served.
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence wrTaken; awvalid && wvalid && !bvalid; endsequence
    sequence inTaken; inValid && inReady && !outValid; endsequence
    a_write_answer: assert property (wrTaken |=> bvalid) else $error("Write unanswered.");
    a_bvalid_held: assert property (bvalid && !bready |=> bvalid) else $error("Answer lost.");
    a_bvalid_once: assert property (bvalid && bready |=> !bvalid) else $error("Answer twice.");
    a_read_answer: assert property (arvalid && !rvalid |=> rvalid) else $error("No read data.");
    a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("Read data moved.");
    a_egress_held:
        assert property (outValid && !outReady |=> outValid && $stable(outQueue))
        else $error("Egress moved.");
    a_ingress_forward:
        // The queue has no bypass, so the word reaches the output two edges after it is taken.
        assert property (inTaken |=> ##1 outValid) else $error("Descriptor not forwarded.");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !bvalid && !rvalid && !outValid)
        else $error("Busy after reset.");
endmodule : qos_sva
bind qos_classify_queue_scheduler qos_sva i_qos_sva (.sys_clk, .rst, .awvalid, .wvalid,
    .bvalid, .bready, .arvalid, .rvalid, .rready, .rdata, .inValid, .inReady, .outValid,
    .outReady, .outQueue);

// >>> tb/egress_sink.sv
// Egress port model that takes descriptors at once or stalls on request.
`timescale 1ns/1ps
module egress_sink (
    input wire logic        sys_clk,  // Clock.
    input wire logic        rst,      // Reset.
    input wire logic        stall,    // Keep the port busy.
    input wire logic        outValid, // Offered.
    output logic            outReady, // Port can take one.
    input wire logic [2:0]  outQueue, // Queue served.
    input wire logic [2:0]  outCos,   // Priority carried.
    input wire logic [31:0] outData   // Descriptor carried.
);
    logic [5:0]  got[$];
    logic [31:0] lastData;
    initial outReady = 1'b0;
    // Ready moves only after an edge, as a real port would, so no item is taken twice.
    always @(posedge sys_clk)
    begin
        if (outValid && outReady && !rst)
        begin
            // Blocking, so a reader that sees the queue grow also sees this word.
            lastData = outData;
            got.push_back({outQueue, outCos});
        end
        outReady <= !rst && !stall;
    end
endmodule : egress_sink

// >>> tb/tb_top.sv
// Self-checking bench for the QoS classifier and egress scheduler.
`timescale 1ns/1ps
module tb_top
    import qos_pkg::*;
;
    logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, inValid;
    logic        awready, wready, bvalid, arready, rvalid, inReady, outValid, outReady;
    logic        inTagged, inIsIp, stall;
    logic [1:0]  bresp, rresp;
    logic [2:0]  inPort, inPcp, outQueue, outCos;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr, inTos;
    logic [31:0] wdata, rdata, inData, outData, rv;
    int          failures, tests_run, cycles;
    qos_classify_queue_scheduler i_qos_classify_queue_scheduler (.sys_clk, .rst, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .inValid, .inReady,
        .inPort, .inTagged, .inPcp, .inIsIp, .inTos, .inData, .outValid, .outReady,
        .outData, .outQueue, .outCos);
    egress_sink i_egress_sink (.sys_clk, .rst, .stall, .outValid, .outReady, .outQueue,
        .outCos, .outData);
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (++cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // Both bus tasks end one edge after the answer so the next call never
    // reassigns a handshake signal in the same time step.
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge sys_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp, er);
        @(posedge sys_clk);
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata, exp);
        check(rresp, er);
        @(posedge sys_clk);
    endtask : axi_rd
    task send(input logic [2:0] p, input logic t, input logic [2:0] c, input logic ip,
              input logic [7:0] tos);
        inPort <= p;
        inTagged <= t;
        inPcp <= c;
        inIsIp <= ip;
        inTos <= tos;
        inData <= inData + 32'h1;
        inValid <= 1'b1;
        do @(posedge sys_clk); while (inReady !== 1'b1);
    endtask : send
    task expq(input logic [2:0] q);
        repeat (100)
            if (i_egress_sink.got.size() == 0)
                @(posedge sys_clk);
        // An empty queue must count as a miss, not read back as queue zero.
        if (i_egress_sink.got.size() == 0)
            check(32'h0, 32'h1);
        else
            check(i_egress_sink.got.pop_front(), {q, q});
    endtask : expq
    task one(input logic [2:0] p, input logic t, input logic [2:0] c, input logic ip,
             input logic [7:0] tos, input logic [2:0] q);
        send(p, t, c, ip, tos);
        inValid <= 1'b0;
        expq(q);
        check(i_egress_sink.lastData, inData);
    endtask : one
    initial
    begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, inValid, inTagged, inIsIp, stall} = '0;
        {awaddr, araddr, wdata, inPort, inPcp, inTos, inData, rv} = '0;
        wstrb = 4'hF;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        axi_rd(OFS_CTRL, 32'h1, RESP_OKAY);
        axi_rd(OFS_PORT_TRUST, 32'hFF, RESP_OKAY);
        axi_rd(OFS_COS_TO_Q, 32'hFAC688, RESP_OKAY);
        axi_rd(OFS_Q_TO_COS, 32'hFAC688, RESP_OKAY);
        axi_rd(OFS_WEIGHT, 32'hFD954321, RESP_OKAY);
        for (int k = 0; k < 8; k++)
            axi_rd(OFS_DSCP_FIRST + 8'(4 * k), {8{k[2:0]}}, RESP_OKAY);
        axi_wr(8'h40, 32'h1, RESP_SLVERR);
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
        axi_wr(OFS_STATUS, 32'hFFFF, RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h0, RESP_OKAY);
        for (int p = 0; p < 8; p++)
            one(3'h1, 1'b1, 3'(p), 1'b0, 8'h00, 3'(p));
        one(3'h1, 1'b0, 3'h6, 1'b1, 8'hE0, 3'h0);
        axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
        for (int k = 0; k < 8; k++)
            one(3'h2, 1'b1, 3'h7, 1'b1, {k[2:0], 3'(7 - k), 2'b11}, k[2:0]);
        one(3'h2, 1'b1, 3'h5, 1'b0, 8'hFF, 3'h0);
        axi_wr(OFS_CTRL, 32'h5, RESP_OKAY);
        one(3'h4, 1'b1, 3'h1, 1'b1, 8'hC0, 3'h6);
        one(3'h4, 1'b1, 3'h2, 1'b0, 8'hC0, 3'h2);
        axi_wr(OFS_PORT_TRUST, 32'hDF, RESP_OKAY);
        axi_wr(OFS_PORT_COS, 32'h18000, RESP_OKAY);
        one(3'h5, 1'b1, 3'h7, 1'b1, 8'hE0, 3'h3);
        axi_wr(OFS_SCHED_MODE, 32'h3, RESP_OKAY);
        stall <= 1'b1;
        rv = {8'h00, 12'o0471, 12'o4701};
        for (int i = 0; i < 4; i++)
            send(3'h0, 1'b1, rv[3*i +: 3], 1'b0, 8'h00);
        inValid <= 1'b0;
        stall <= 1'b0;
        for (int i = 4; i < 8; i++)
            expq(rv[3*i +: 3]);
        stall <= 1'b1;
        for (int i = 0; i < 17; i++)
            send(3'h0, 1'b1, 3'h3, 1'b0, 8'h00);
        @(posedge sys_clk);
        check(inReady, 1'b0);
        inValid <= 1'b0;
        axi_rd(OFS_STATUS, 32'h808, RESP_OKAY);
        stall <= 1'b0;
        repeat (17) expq(3'h3);
        axi_rd(OFS_STATUS, 32'h0, RESP_OKAY);
        // Queue 1 (weight 2) gets two turns per turn of queue 0 (weight 1); the first
        // word sent is already in the output stage when the stall ends.
        stall <= 1'b1;
        for (int i = 0; i < 5; i++)
            send(3'h0, 1'b1, 3'(i > 1), 1'b0, 8'h00);
        inValid <= 1'b0;
        stall <= 1'b0;
        rv = 32'h16;
        for (int i = 0; i < 5; i++)
            expq(3'(rv[i]));
        axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
        one(3'h0, 1'b1, 3'h7, 1'b1, 8'hE0, 3'h0);
        wrap_up();
    end
endmodule : tb_top
